/* File: hw/fws_pkg.sv */
// Purpose: Shared constants and types for the flash status poller.
// Assumes: 100 MHz clock, byte-wide flash data bus.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
package fws_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;
  // Read/write strobe low time and recovery time of one bus cycle.
  localparam int T_ACCESS_NS = 70;
  localparam int T_RECOVER_NS = 30;
  localparam int ACCESS_CLKS =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
  localparam int RECOVER_CLKS =
    (T_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int FLASH_ADDR_W = 20;
  localparam int FLASH_DATA_W = 8;
  localparam int AXI_ADDR_W = 8;

  // Status bit positions on the flash data bus.
  localparam int DATA_POLL_POS = 7;
  localparam int TOGGLE_ONE_POS = 6;
  localparam int TIMEOUT_FLAG_POS = 5;
  localparam int SECTOR_TOGGLE_POS = 2;

  localparam logic [AXI_ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] ADDR_OFS = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] WDATA_OFS = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFS = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] RDATA_OFS = 8'h10;

  localparam int CTRL_CMD_LSB = 0;
  localparam int CTRL_ABORT_POS = 8;
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_DATA_POLL = 3'h3;
  localparam logic [2:0] CMD_TOGGLE_POLL = 3'h4;

  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_DONE_POS = 1;
  localparam int STAT_FAIL_POS = 2;
  localparam int STAT_READY_POS = 3;
  localparam int STAT_TIMEOUT_POS = 4;

  localparam logic [FLASH_ADDR_W-1:0] ADDR_RESET = 20'h00000;
  localparam logic [FLASH_DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic isWrite;
    logic [FLASH_ADDR_W-1:0] addr;
    logic [FLASH_DATA_W-1:0] data;
  } fws_cycle_req_s;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_SINGLE = 9'h002,
    S_DP_READ = 9'h004,
    S_DP_RECHK = 9'h008,
    S_TG_FIRST = 9'h010,
    S_TG_NEXT = 9'h020,
    S_TG_RECHK_A = 9'h040,
    S_TG_RECHK_B = 9'h080,
    S_FINAL = 9'h100
  } fws_state_e;
endpackage : fws_pkg

/* File: hw/fws_bus_cycle.sv */
// Purpose: Runs one read or one write cycle on the flash pins.
// Assumes: Data input is already synchronised by the caller.
// Notes: A start while a cycle runs is ignored.
`timescale 1ns/1ps
module fws_bus_cycle import fws_pkg::*; #(
  parameter int ACCESS = ACCESS_CLKS,
  parameter int RECOVER = RECOVER_CLKS
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire fws_cycle_req_s req,
  input wire logic [FLASH_DATA_W-1:0] dqSync,
  output logic busy,
  output logic done,
  output logic [FLASH_DATA_W-1:0] rdata_reg,
  output logic [FLASH_ADDR_W-1:0] addr_reg,
  output logic [FLASH_DATA_W-1:0] dqOut_reg,
  output logic dqOe_reg,
  output logic ceN_reg,
  output logic oeN_reg,
  output logic weN_reg
);
  localparam int CYCLE_LAT = ACCESS + RECOVER;

  if (ACCESS < SYNC_STAGES + 1 || ACCESS > 15 || RECOVER < 1
      || RECOVER > 15) begin : gBadTiming
    $error("Bus cycle timing counts out of range.");
  end

  logic active_reg;
  logic recover_reg;
  logic isWrite_reg;
  logic [3:0] cnt_reg;

  assign busy = active_reg | recover_reg;
  assign done = recover_reg && (cnt_reg == 4'h0);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      active_reg <= 1'b0;
      recover_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else if (start && !busy) begin
      active_reg <= 1'b1;
      cnt_reg <= 4'(ACCESS - 1);
    end else if (active_reg) begin
      if (cnt_reg == 4'h0) begin
        active_reg <= 1'b0;
        recover_reg <= 1'b1;
        cnt_reg <= 4'(RECOVER - 1);
      end else begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end else if (recover_reg) begin
      if (cnt_reg == 4'h0) begin
        recover_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

  // Write data is driven through the recovery time so it still stands
  // at the rising write strobe, where the flash latches it.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      isWrite_reg <= 1'b0;
      addr_reg <= ADDR_RESET;
      dqOut_reg <= DATA_RESET;
      dqOe_reg <= 1'b0;
      ceN_reg <= 1'b1;
      oeN_reg <= 1'b1;
      weN_reg <= 1'b1;
    end else if (start && !busy) begin
      isWrite_reg <= req.isWrite;
      addr_reg <= req.addr;
      dqOut_reg <= req.data;
      dqOe_reg <= req.isWrite;
      ceN_reg <= 1'b0;
      oeN_reg <= req.isWrite;
      weN_reg <= !req.isWrite;
    end else if (active_reg && cnt_reg == 4'h0) begin
      ceN_reg <= 1'b1;
      oeN_reg <= 1'b1;
      weN_reg <= 1'b1;
    end else if (done) begin
      dqOe_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_reg <= DATA_RESET;
    end else if (active_reg && cnt_reg == 4'h0 && !isWrite_reg) begin
      rdata_reg <= dqSync;
    end
  end

  cycle_length_a: assert property (@(posedge clock) disable iff (sys_rst)
    start && !busy |-> ##[CYCLE_LAT:CYCLE_LAT] done)
    else $error("Bus cycle did not end after its fixed length.");

  strobe_excl_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(oeN_reg == 1'b0 && weN_reg == 1'b0) && (!dqOe_reg || oeN_reg))
    else $error("Read and write strobes or drivers overlap.");
endmodule : fws_bus_cycle

/* File: hw/fws_status_poller.sv */
// Purpose: Host controller that runs flash bus cycles and status polling.
// Assumes: Software gives orders over AXI4-Lite; flash pins are async.
// Notes: Polls by data-poll bit or toggle bit; reports done and failure.
`timescale 1ns/1ps
// Summary of operation
// R01 - Device drives inverted bit seven while programming.
// R02 - Device drives true bit seven after programming.
// R03 - Host polls at the programmed address.
// R04 - Protected program target: status about 1 us.
// R05 - Erase shows bit seven low, then high.
// R06 - Host polls inside a sector chosen for erase.
// R07 - All sectors protected: status about 100 us.
// R08 - Protected sectors among chosen ones are skipped.
// R09 - Take array data only from next read.
// R10 - Recheck bit seven after timeout flag rises.
// R11 - Ready/busy pin low while programming or erasing.
// R12 - Status valid after last write strobe edge.
// R13 - Toggle bit inverts each read while busy.
// R14 - Toggle bit valid in erase time-out window.
// R15 - All sectors protected: toggle about 100 us.
// R16 - Protected program target: toggle about 1 us.
// R17 - Toggle stops in erase pause, resumes programming.
// R18 - Sector toggle bit toggles in chosen sectors.
// R19 - Read twice, compare toggle, then read data.
// R20 - Toggling with timeout flag: recheck, else fail.
// R21 - Returning to polling restarts from first step.
// R22 - Timeout flag high means the operation failed.
// R23 - Busy region reads return status, not data.
module fws_status_poller import fws_pkg::*; (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [FLASH_ADDR_W-1:0] flashAddr,
  output logic [FLASH_DATA_W-1:0] flashDqOut,
  output logic flashDqOe,
  input wire logic [FLASH_DATA_W-1:0] flashDqIn,
  output logic flashCeN,
  output logic flashOeN,
  output logic flashWeN,
  input wire logic readyBusyN
);
  fws_state_e state_reg;
  logic [FLASH_DATA_W-1:0] dqMeta_reg;
  logic [FLASH_DATA_W-1:0] dqSync_reg;
  logic rybyMeta_reg;
  logic rybySync_reg;
  logic [FLASH_ADDR_W-1:0] addr_reg;
  logic [FLASH_DATA_W-1:0] wdata_reg;
  logic [FLASH_DATA_W-1:0] rdata_reg;
  logic isWrite_reg;
  logic launched_reg;
  logic toggle_reg;
  logic done_reg;
  logic fail_reg;
  logic timeout_reg;
  logic engStart;
  logic engBusy;
  logic engDone;
  logic [FLASH_DATA_W-1:0] engRdata;
  logic wrFire;
  logic rdFire;
  logic cmdAccept;
  logic ctrlWrite;
  logic ctlBusy;
  logic [2:0] cmd;
  logic [31:0] rdataNext;
  logic rdHit;
  logic wrHit;
  logic pollBit;
  logic toggleBit;
  logic timeoutBit;
  fws_cycle_req_s req;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
      input logic [31:0] upd, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = upd[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // Pin inputs pass two flops before any logic looks at them.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dqMeta_reg <= DATA_RESET;
      dqSync_reg <= DATA_RESET;
      rybyMeta_reg <= 1'b1;
      rybySync_reg <= 1'b1;
    end else begin
      dqMeta_reg <= flashDqIn;
      dqSync_reg <= dqMeta_reg;
      rybyMeta_reg <= readyBusyN;
      rybySync_reg <= rybyMeta_reg; // see R11
    end
  end

  // Write and read channels are each accepted with a one-cycle ready.
  assign wrFire = s_axi_awvalid && s_axi_awready;
  assign rdFire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid) begin
      s_axi_bvalid <= !s_axi_bready;
    end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
  end

  assign wrHit = (s_axi_awaddr == CTRL_OFS) || (s_axi_awaddr == ADDR_OFS)
    || (s_axi_awaddr == WDATA_OFS);
  assign ctrlWrite = wrFire && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0];
  assign cmd = s_axi_wdata[CTRL_CMD_LSB +: 3];
  assign ctlBusy = (state_reg != S_IDLE) || launched_reg;
  // Commands arriving while busy are dropped, but an abort still applies; status shows busy meanwhile.
  assign cmdAccept = ctrlWrite && !ctlBusy && cmd >= CMD_WRITE
    && cmd <= CMD_TOGGLE_POLL;

  // Address and data are frozen during a command so polls stay put.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_reg <= ADDR_RESET;
      wdata_reg <= DATA_RESET;
    end else if (wrFire && !ctlBusy) begin
      if (s_axi_awaddr == ADDR_OFS) begin
        addr_reg <= FLASH_ADDR_W'(mergeBytes(32'(addr_reg), s_axi_wdata,
          s_axi_wstrb));
      end
      if (s_axi_awaddr == WDATA_OFS) begin
        wdata_reg <= FLASH_DATA_W'(mergeBytes(32'(wdata_reg), s_axi_wdata,
          s_axi_wstrb));
      end
    end
  end

  assign rdHit = (s_axi_araddr == CTRL_OFS) || (s_axi_araddr == ADDR_OFS)
    || (s_axi_araddr == WDATA_OFS) || (s_axi_araddr == STATUS_OFS)
    || (s_axi_araddr == RDATA_OFS);

  always_comb begin
    rdataNext = 32'h00000000;
    unique case (s_axi_araddr)
      ADDR_OFS: rdataNext = 32'(addr_reg);
      WDATA_OFS: rdataNext = 32'(wdata_reg);
      STATUS_OFS: begin
        rdataNext[STAT_BUSY_POS] = ctlBusy;
        rdataNext[STAT_DONE_POS] = done_reg;
        rdataNext[STAT_FAIL_POS] = fail_reg;
        rdataNext[STAT_READY_POS] = rybySync_reg;
        rdataNext[STAT_TIMEOUT_POS] = timeout_reg;
      end
      RDATA_OFS: rdataNext = 32'(rdata_reg);
      default: rdataNext = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdataNext;
      s_axi_rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      s_axi_rvalid <= !s_axi_rready;
    end else if (s_axi_arvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // A cycle is launched whenever not idle and none is pending, so a polling state that is held
  // launches one per read; a poll that was aborted keeps launched set until its cycle ends, so a read ending after the abort cycle is not evaluated.
  assign engStart = (state_reg != S_IDLE) && !launched_reg;
  assign pollBit = engRdata[DATA_POLL_POS];
  assign toggleBit = engRdata[TOGGLE_ONE_POS];
  assign timeoutBit = engRdata[TIMEOUT_FLAG_POS];
  assign req = '{isWrite: (state_reg == S_SINGLE) && isWrite_reg,
    addr: addr_reg, data: wdata_reg}; // see R03, R06, R13

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      launched_reg <= 1'b0;
    end else if (engStart) begin
      launched_reg <= 1'b1;
    end else if (engDone) begin
      launched_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= S_IDLE;
      isWrite_reg <= 1'b0;
      toggle_reg <= 1'b0;
    end else if (ctrlWrite && s_axi_wdata[CTRL_ABORT_POS]) begin
      state_reg <= S_IDLE;
    end else if (cmdAccept) begin
      isWrite_reg <= (cmd == CMD_WRITE);
      unique case (cmd)
        CMD_DATA_POLL: state_reg <= S_DP_READ;
        CMD_TOGGLE_POLL: state_reg <= S_TG_FIRST; // see R21
        default: state_reg <= S_SINGLE;
      endcase
    end else if (engDone && launched_reg) begin
      unique case (state_reg)
        S_DP_READ: begin
          if (pollBit == wdata_reg[DATA_POLL_POS]) begin
            state_reg <= S_FINAL; // see R09
          end else if (timeoutBit) begin
            state_reg <= S_DP_RECHK; // see R10, R22
          end
        end
        S_DP_RECHK: begin
          state_reg <= (pollBit == wdata_reg[DATA_POLL_POS]) ? S_FINAL
            : S_IDLE; // see R10
        end
        S_TG_FIRST: begin
          toggle_reg <= toggleBit;
          state_reg <= S_TG_NEXT; // see R19
        end
        S_TG_NEXT: begin
          toggle_reg <= toggleBit;
          if (toggleBit == toggle_reg) begin
            state_reg <= S_FINAL; // see R19
          end else if (timeoutBit) begin
            state_reg <= S_TG_RECHK_A; // see R20, R22
          end
        end
        S_TG_RECHK_A: begin
          toggle_reg <= toggleBit;
          state_reg <= S_TG_RECHK_B;
        end
        S_TG_RECHK_B: begin
          state_reg <= (toggleBit == toggle_reg) ? S_FINAL : S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // A failed poll leaves the flash in status mode; software must write
  // the reset command with a plain write cycle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      timeout_reg <= 1'b0;
      rdata_reg <= DATA_RESET;
    end else if (cmdAccept) begin
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else if (engDone && launched_reg && state_reg != S_IDLE) begin
      // Bit five means a timeout only on a status read, never on data.
      if (timeoutBit && ((state_reg == S_DP_READ
          && pollBit != wdata_reg[DATA_POLL_POS])
          || (state_reg == S_TG_NEXT && toggleBit != toggle_reg))) begin
        timeout_reg <= 1'b1; // see R22
      end
      if (state_reg == S_FINAL || state_reg == S_SINGLE) begin
        done_reg <= 1'b1;
        if (!isWrite_reg || state_reg == S_FINAL) begin
          rdata_reg <= engRdata; // see R09
        end
      end
      if ((state_reg == S_DP_RECHK && pollBit != wdata_reg[DATA_POLL_POS])
          || (state_reg == S_TG_RECHK_B && toggleBit != toggle_reg)) begin
        done_reg <= 1'b1;
        fail_reg <= 1'b1; // see R10, R20
        rdata_reg <= engRdata;
      end
    end
  end

  fws_bus_cycle uCycle (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(engStart),
    .req(req),
    .dqSync(dqSync_reg),
    .busy(engBusy),
    .done(engDone),
    .rdata_reg(engRdata),
    .addr_reg(flashAddr),
    .dqOut_reg(flashDqOut),
    .dqOe_reg(flashDqOe),
    .ceN_reg(flashCeN),
    .oeN_reg(flashOeN),
    .weN_reg(flashWeN)
  );

  logic evalDone;
  assign evalDone = engDone && launched_reg && !ctrlWrite;

  dp_match_a: assert property (@(posedge clock) disable iff (sys_rst) // see R09
    evalDone && state_reg == S_DP_READ
    && pollBit == wdata_reg[DATA_POLL_POS] |=> state_reg == S_FINAL)
    else $error("Data poll match did not lead to the final read.");
  dp_recheck_a: assert property (@(posedge clock) disable iff (sys_rst) // see R10
    evalDone && state_reg == S_DP_READ && timeoutBit
    && pollBit != wdata_reg[DATA_POLL_POS] |=> state_reg == S_DP_RECHK)
    else $error("Timeout flag did not force a data poll recheck.");
  dp_fail_a: assert property (@(posedge clock) disable iff (sys_rst) // see R10
    evalDone && state_reg == S_DP_RECHK
    && pollBit != wdata_reg[DATA_POLL_POS]
    |=> fail_reg && done_reg && state_reg == S_IDLE)
    else $error("Failed data poll recheck not reported.");
  tg_done_a: assert property (@(posedge clock) disable iff (sys_rst) // see R19
    evalDone && state_reg == S_TG_NEXT && toggleBit == toggle_reg
    |=> state_reg == S_FINAL ##1 !done_reg)
    else $error("Steady toggle bit did not lead to one more read.");
  tg_recheck_a: assert property (@(posedge clock) disable iff (sys_rst) // see R20
    evalDone && state_reg == S_TG_NEXT && toggleBit != toggle_reg
    && timeoutBit |=> state_reg == S_TG_RECHK_A)
    else $error("Toggle with timeout flag was not rechecked.");
  tg_fail_a: assert property (@(posedge clock) disable iff (sys_rst) // see R20
    evalDone && state_reg == S_TG_RECHK_B && toggleBit != toggle_reg
    |=> fail_reg && state_reg == S_IDLE)
    else $error("Toggle still running after recheck not failed.");
  tg_restart_a: assert property (@(posedge clock) disable iff (sys_rst) // see R21
    cmdAccept && cmd == CMD_TOGGLE_POLL && !s_axi_wdata[CTRL_ABORT_POS]
    |=> state_reg == S_TG_FIRST && !done_reg && !fail_reg)
    else $error("Toggle poll did not start from its first read.");
  poll_addr_a: assert property (@(posedge clock) disable iff (sys_rst) // see R03
    !flashCeN && state_reg != S_IDLE |-> flashAddr == addr_reg)
    else $error("Poll read left the programmed address.");
  final_data_a: assert property (@(posedge clock) disable iff (sys_rst) // see R09
    evalDone && state_reg == S_FINAL |=> done_reg && !fail_reg
    && rdata_reg == $past(engRdata))
    else $error("Array data not taken from the read after status.");

  dp_ok_c: cover property (@(posedge clock) disable iff (sys_rst)
    evalDone && state_reg == S_DP_RECHK
    && pollBit == wdata_reg[DATA_POLL_POS]);
  dp_fail_c: cover property (@(posedge clock) disable iff (sys_rst)
    $rose(fail_reg) && $past(state_reg) == S_DP_RECHK);
  tg_ok_c: cover property (@(posedge clock) disable iff (sys_rst)
    evalDone && state_reg == S_TG_RECHK_B && toggleBit == toggle_reg);
  tg_fail_c: cover property (@(posedge clock) disable iff (sys_rst)
    $rose(fail_reg) && $past(state_reg) == S_TG_RECHK_B);
endmodule : fws_status_poller

/* File: tb/fws_flash_model.sv */
// Purpose: Behavioural flash device behind the poller's pins.
// Assumes: One operation at a time; 0xF0 resets; top address bit protects.
// Notes: The bench resolves the open-drain busy line with a pull-up.
`timescale 1ns/1ps
module fws_flash_model import fws_pkg::*; (
  input wire logic [FLASH_ADDR_W-1:0] addr,
  input wire logic [FLASH_DATA_W-1:0] dqIn,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic failNext,
  input wire logic [3:0] busyReads,
  output logic [FLASH_DATA_W-1:0] dqOut,
  output logic rbOe
);
  logic [7:0] mem [int];
  logic busy = 1'b0;
  logic erasing = 1'b0;
  logic failed = 1'b0;
  logic tgl = 1'b0;
  logic armed = 1'b0;
  logic prot = 1'b0;
  logic [7:0] pd = 8'h00;
  logic [7:0] last = 8'h00;
  logic [7:0] cur;
  int pa = 0;
  int left = 0;
  assign rbOe = busy;
  // A released bus shows the inverse of the last byte, never a stale copy.
  always @* begin
    if (busy) begin
      cur = {erasing ? 1'b0 : ~pd[7], tgl, failed, 2'h0, erasing & tgl,
             2'h0};
    end else begin
      cur = mem.exists(addr) ? mem[addr] : 8'hFF;
    end
    dqOut = (!oeN && !ceN) ? cur : ~last;
  end
  // The power-up edge of the strobe must not start an operation.
  always @(negedge weN) armed = 1'b1;
  always @(posedge weN) begin
    if (armed && dqIn == 8'hF0) begin
      busy = 1'b0;
      failed = 1'b0;
    end else if (armed && !busy) begin
      busy = 1'b1;
      pa = addr;
      pd = dqIn;
      erasing = (dqIn == 8'h30);
      failed = failNext;
      left = busyReads;
      prot = addr[FLASH_ADDR_W-1];
    end
    armed = 1'b0;
  end
  always @(posedge oeN) begin
    last = cur;
    if (busy) begin
      tgl = ~tgl;
      if (!failed && !prot && left == 0) begin
        busy = 1'b0;
        mem[pa] = erasing ? 8'hFF : pd;
      end else if (!failed && !prot) begin
        left--;
      end
    end
  end
  // A protected target shows status for a fixed time, then array data.
  always @(posedge busy) begin
    if (prot) begin
      #(erasing ? 100000 : 1000);
      busy = 1'b0;
      prot = 1'b0;
    end
  end
endmodule : fws_flash_model

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the flash status poller.
// Assumes: Flash model on the pins, AXI4-Lite master tasks here.
// Notes: Expected array contents live in a bench-side table.
`timescale 1ns/1ps
module tb;
  import fws_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] awAddr = 8'h00;
  logic [7:0] arAddr = 8'h00;
  logic [31:0] wData = 32'h0;
  logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, failNext = 1'b0;
  logic [3:0] busyReads = 4'h0;
  logic awReady, wReady, bValid, arReady, rValid, dqOe, ceN, oeN, weN;
  logic rbOe;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [19:0] fAddr;
  logic [7:0] dqOut, dqIn;
  int miscompares = 0;
  int testsRun = 0;
  logic [31:0] seed = 32'hAB01;
  logic [7:0] expMem [int];
  wire rbN = rbOe ? 1'b0 : 1'b1;
  initial begin
    forever #5 clock = ~clock;
  end
  fws_status_poller DUT (.clock(clock), .sys_rst(sysRst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(1'b1), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(1'b1), .flashAddr(fAddr), .flashDqOut(dqOut),
    .flashDqOe(dqOe), .flashDqIn(dqIn), .flashCeN(ceN),
    .flashOeN(oeN), .flashWeN(weN), .readyBusyN(rbN));
  fws_flash_model flash (.addr(fAddr), .dqIn(dqOut), .ceN(ceN),
    .oeN(oeN), .weN(weN), .failNext(failNext), .busyReads(busyReads),
    .dqOut(dqIn), .rbOe(rbOe));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic giveVerdict();
    if (miscompares == 0 && testsRun > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict
  task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t data %h expected %h", $time, got, exp);
    end
  endtask : chkData
  task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t resp %h expected %h", $time, got, exp);
    end
  endtask : chkResp
  // Ready lines are tied high, which the protocol allows at all times.
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic awPend;
    logic wPend;
    awPend = 1'b1;
    wPend = 1'b1;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (awPend || wPend) begin
      @(posedge clock);
      if (awReady === 1'b1) begin
        awValid <= 1'b0;
        awPend = 1'b0;
      end
      if (wReady === 1'b1) begin
        wValid <= 1'b0;
        wPend = 1'b0;
      end
    end
    while (bValid !== 1'b1) @(posedge clock);
    chkResp(bResp, er);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    arAddr <= a;
    arValid <= 1'b1;
    do @(posedge clock); while (arReady !== 1'b1);
    arValid <= 1'b0;
    while (rValid !== 1'b1) @(posedge clock);
    d = rData;
    r = rResp;
  endtask : axr
  task automatic runOp(input logic [2:0] cmd, input logic [31:0] msk,
                       input logic [31:0] expSt, input int expRd);
    logic [31:0] v;
    logic [1:0] r;
    v = 32'h0;
    axw(CTRL_OFS, {29'h0, cmd}, RESP_OKAY);
    while (v[STAT_DONE_POS] !== 1'b1) axr(STATUS_OFS, v, r);
    chkData(v & msk, expSt);
    if (expRd >= 0) begin
      axr(RDATA_OFS, v, r);
      chkData(v, expRd);
    end
  endtask : runOp
  // The ready bit is masked: it is low after a program or erase but high after the 0xF0 reset.
  task automatic prog(input logic [19:0] a, input logic [7:0] d);
    axw(ADDR_OFS, {12'h0, a}, RESP_OKAY);
    axw(WDATA_OFS, {24'h0, d}, RESP_OKAY);
    runOp(CMD_WRITE, 32'h17, 32'h2, -1);
  endtask : prog
  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    giveVerdict();
  end
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic [19:0] a;
    logic [7:0] d;
    repeat (5) @(posedge clock);
    sysRst <= 1'b0;
    @(posedge clock);
    axr(STATUS_OFS, v, r);
    chkData(v, 32'h8);
    axr(8'h14, v, r);
    chkResp(r, RESP_SLVERR);
    axw(8'h18, 32'h1, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      a = {1'b0, v[18:0]};
      d = v[31:24] & 8'hDF;
      busyReads <= v[23:20];
      prog(a, d);
      expMem[a] = d;
      runOp(i[0] ? CMD_TOGGLE_POLL : CMD_DATA_POLL, ALL, 32'hA,
            expMem[a]);
      runOp(CMD_READ, ALL, 32'hA, expMem[a]);
    end
    prog(a, 8'h30);
    axw(WDATA_OFS, 32'hFF, RESP_OKAY);
    expMem[a] = 8'hFF;
    runOp(CMD_DATA_POLL, ALL, 32'hA, expMem[a]);
    failNext <= 1'b1;
    prog(a ^ 20'h1, 8'h55);
    failNext <= 1'b0;
    runOp(CMD_DATA_POLL, ALL, 32'h16, -1);
    runOp(CMD_TOGGLE_POLL, ALL, 32'h16, -1);
    axw(WDATA_OFS, 32'hF0, RESP_OKAY);
    runOp(CMD_WRITE, 32'h17, 32'h2, -1);
    runOp(CMD_READ, ALL, 32'hA, 8'hFF);
    prog({1'b1, a[18:0]}, 8'h80);
    runOp(CMD_DATA_POLL, ALL, 32'hA, 8'hFF);
    prog({1'b1, a[18:0]}, 8'h30);
    axw(WDATA_OFS, 32'hFF, RESP_OKAY);
    runOp(CMD_DATA_POLL, ALL, 32'hA, 8'hFF);
    busyReads <= 4'hF;
    prog(a, 8'h11);
    expMem[a] = 8'h11;
    axw(CTRL_OFS, {29'h0, CMD_TOGGLE_POLL}, RESP_OKAY);
    axw(ADDR_OFS, 32'h0, RESP_OKAY);
    axr(ADDR_OFS, v, r);
    chkData(v, {12'h0, a});
    axw(CTRL_OFS, 32'h100, RESP_OKAY);
    v = 32'h1;
    while (v[STAT_BUSY_POS] !== 1'b0) axr(STATUS_OFS, v, r);
    runOp(CMD_DATA_POLL, ALL, 32'hA, expMem[a]);
    giveVerdict();
  end
endmodule : tb
